// ### core/dual_timer_io_irq_regs.sv
// Register access over AHB-Lite is this design's own decision.
`default_nettype none
`include "dual_timer_defines.svh"
module dual_timer_io_irq_regs (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Timer pins
  input  wire logic        timer_pin_a_in,
  output logic             timer_pin_a_out,
  output logic             timer_pin_a_oe_n,
  input  wire logic        timer_pin_b_in,
  // System lines
  output logic             pwm_line,
  output logic             irq_a,
  output logic             irq_b
);
  import dual_timer_pkg::*;

  ctl_state_t  c_reg;
  ctl_state_t  c_next;
  data_state_t d_reg;
  data_state_t d_next;
  bus_access_t access;
  logic        edge_a;
  logic        edge_b;
  logic [1:0]  pin_level;
  logic [1:0]  pin_rising;
  logic [1:0]  pin_hit;
  logic        tick;
  logic        pin_b_is_event;
  logic        accumulate_level;
  logic        step_one;
  logic        step_two;
  logic        toggle_a;
  logic        pin_a_drives;
  logic [1:0]  mode;
  logic [3:0]  set_flags;
  logic [3:0]  clear_flags;
  logic [31:0] read_value;

  // ***********************************************************************
  // Bus port and its access strobe
  // ***********************************************************************
  ahb_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .haddr     (haddr),
    .hready    (hready),
    .hreadyout (hreadyout),
    .access    (access)
  );

  // ***********************************************************************
  // Pin edges, entry 0 is pin A and entry 1 is pin B
  // ***********************************************************************
  assign pin_level = {timer_pin_b_in, timer_pin_a_in};
  assign pin_rising = {c_reg.mode_control.pin_b_edge_select,
                       c_reg.mode_control.pin_a_edge_select};
  assign edge_a = pin_hit[0];
  assign edge_b = pin_hit[1];

  for (genvar g = 0; g < 2; g++) begin : g_pin
    pin_edge u_edge (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .pin           (pin_level[g]),
      .rising_select (pin_rising[g]),
      .edge_seen     (pin_hit[g])
    );
  end

  // ***********************************************************************
  // Counter clock choice
  // ***********************************************************************
  function automatic logic clock_step(input logic [2:0] sel, input logic tk,
                                      input logic ev, input logic lvl,
                                      input logic ext_ok);
    logic step;
    step = 1'b0;
    case (sel)
      `CSEL_PRESCALED: step = tk;
      `CSEL_EXT_EVENT: step = ext_ok && ev;
      `CSEL_PULSE_ACC: step = ext_ok && tk && lvl;
      default:         step = 1'b0;
    endcase
    return step;
  endfunction

  // ***********************************************************************
  // Next state
  // ***********************************************************************
  always_comb begin
    c_next = c_reg;
    d_next = d_reg;
    set_flags = 4'h0;
    clear_flags = 4'h0;
    toggle_a = 1'b0;
    read_value = 32'h0000_0000;
    mode = c_reg.mode_control.mode_select;

    // ****************************************
    // Prescaler divides the system clock by value plus one
    // ****************************************
    tick = (c_reg.presc_cnt == 8'h00);
    c_next.presc_cnt = tick ? c_reg.prescaler : c_reg.presc_cnt - 8'h01;

    // ****************************************
    // Pin B as clock input
    // ****************************************
    pin_b_is_event = (mode == `MODE_DUAL_INDEP) ||
                     ((mode == `MODE_PWM) && !c_reg.mode_control.pulse_train_start);
    accumulate_level = (timer_pin_b_in == c_reg.mode_control.pin_b_edge_select);

    step_one = c_reg.mode_control.module_enable &&
               ((mode != `MODE_DUAL_CAPTURE) || c_reg.started_one) &&
               clock_step(c_reg.clock_unit.one_select, tick, edge_b,
                          accumulate_level, pin_b_is_event);
    step_two = c_reg.mode_control.module_enable &&
               ((mode != `MODE_CAPTURE_TIMER) || c_reg.started_two) &&
               clock_step(c_reg.clock_unit.two_select, tick, edge_b,
                          accumulate_level, pin_b_is_event);

    // ****************************************
    // Counter one
    // ****************************************
    if (step_one) begin
      if (d_reg.counter_one == 16'h0000) begin
        case (mode)
          `MODE_PWM: begin
            if (c_reg.reload_from_b) begin
              d_next.counter_one = d_reg.capture_reload_b;
              set_flags[`SRC_B] = 1'b1;
            end else begin
              d_next.counter_one = d_reg.capture_reload_a;
              set_flags[`SRC_A] = 1'b1;
            end
            c_next.reload_from_b = !c_reg.reload_from_b;
            toggle_a = 1'b1;
          end
          `MODE_DUAL_CAPTURE: begin
            d_next.counter_one = `COUNTER_PRESET;
            set_flags[`SRC_C] = 1'b1;
          end
          default: begin
            d_next.counter_one = d_reg.capture_reload_a;
            set_flags[`SRC_A] = 1'b1;
            toggle_a = 1'b1;
          end
        endcase
      end else begin
        d_next.counter_one = d_reg.counter_one - 16'h0001;
      end
    end

    // ****************************************
    // Counter two
    // ****************************************
    if (step_two) begin
      if (d_reg.counter_two == 16'h0000) begin
        if (mode == `MODE_DUAL_INDEP) begin
          d_next.counter_two = d_reg.capture_reload_b;
        end else begin
          d_next.counter_two = `COUNTER_PRESET;
        end
        set_flags[`SRC_D] = 1'b1;
      end else begin
        d_next.counter_two = d_reg.counter_two - 16'h0001;
      end
    end

    // ****************************************
    // Input captures
    // ****************************************
    if (mode == `MODE_DUAL_CAPTURE) begin
      if (edge_a) begin
        d_next.capture_reload_a = d_reg.counter_one;
        if (c_reg.mode_control.pin_a_function_enable) begin
          d_next.counter_one = `COUNTER_PRESET;
        end
        set_flags[`SRC_A] = 1'b1;
        c_next.started_one = 1'b1;
      end
      if (edge_b) begin
        if (c_reg.mode_control.pin_b_function_enable) begin
          d_next.capture_reload_a = d_reg.counter_one;
          d_next.counter_one = `COUNTER_PRESET;
        end else begin
          d_next.capture_reload_b = d_reg.counter_one;
        end
        set_flags[`SRC_B] = 1'b1;
        c_next.started_one = 1'b1;
      end
    end else if ((mode == `MODE_CAPTURE_TIMER) && edge_b) begin
      d_next.capture_reload_b = d_reg.counter_two;
      if (c_reg.mode_control.pin_b_function_enable) begin
        d_next.counter_two = `COUNTER_PRESET;
      end
      set_flags[`SRC_B] = 1'b1;
      c_next.started_two = 1'b1;
    end

    // ****************************************
    // Pin A toggle flips the stored level itself
    // ****************************************
    if (toggle_a && c_reg.mode_control.pin_a_function_enable) begin
      c_next.mode_control.pin_a_output_level =
        !c_reg.mode_control.pin_a_output_level;
    end

    // ****************************************
    // Register writes, same offsets in every instance
    // ****************************************
    if (access.valid && access.write) begin
      case (access.addr)
        `OFS_COUNTER_ONE: begin
          d_next.counter_one = hwdata[15:0];
        end
        `OFS_CAPTURE_RELOAD_A: begin
          if (c_reg.mode_control.module_enable) begin
            d_next.capture_reload_a = hwdata[15:0];
          end
        end
        `OFS_CAPTURE_RELOAD_B: begin
          if (c_reg.mode_control.module_enable) begin
            d_next.capture_reload_b = hwdata[15:0];
          end
        end
        `OFS_COUNTER_TWO: begin
          d_next.counter_two = hwdata[15:0];
        end
        `OFS_CLOCK_PRESCALER: begin
          c_next.prescaler = hwdata[7:0];
        end
        `OFS_CLOCK_UNIT_CTRL: begin
          c_next.clock_unit = hwdata[5:0];
        end
        `OFS_MODE_CONTROL: begin
          c_next.mode_control = hwdata[8:0];
          c_next.started_one = 1'b0;
          c_next.started_two = 1'b0;
          c_next.reload_from_b = 1'b0;
        end
        `OFS_INTERRUPT_CONTROL: begin
          c_next.source_interrupt_enable = hwdata[3:0];
        end
        `OFS_INTERRUPT_CLEAR: begin
          clear_flags = hwdata[3:0];
        end
        default: ;
      endcase
    end

    // ****************************************
    // Flags: a set in the clearing cycle wins
    // ****************************************
    c_next.pending = (c_reg.pending & ~clear_flags) | set_flags;

    // ****************************************
    // Register reads
    // ****************************************
    case (access.addr)
      `OFS_COUNTER_ONE:       read_value = {16'h0000, d_reg.counter_one};
      `OFS_CAPTURE_RELOAD_A:  read_value = {16'h0000, d_reg.capture_reload_a};
      `OFS_CAPTURE_RELOAD_B:  read_value = {16'h0000, d_reg.capture_reload_b};
      `OFS_COUNTER_TWO:       read_value = {16'h0000, d_reg.counter_two};
      `OFS_CLOCK_PRESCALER:   read_value = {24'h000000, c_reg.prescaler};
      `OFS_CLOCK_UNIT_CTRL:   read_value = {26'h0, c_reg.clock_unit};
      `OFS_MODE_CONTROL:      read_value = {23'h0, c_reg.mode_control};
      `OFS_INTERRUPT_CONTROL: read_value = {28'h0000000, c_reg.source_interrupt_enable};
      `OFS_INTERRUPT_CLEAR:   read_value = {28'h0000000, c_reg.pending};
      default:                read_value = 32'h0000_0000;
    endcase
    if (access.valid && !access.write) begin
      c_next.hrdata = read_value;
    end

    // ****************************************
    // Interrupt lines
    // ****************************************
    c_next.irq_a = |(c_next.pending[`SRC_C:`SRC_A] &
                     c_next.source_interrupt_enable[`SRC_C:`SRC_A]);
    c_next.irq_b = c_next.pending[`SRC_D] &&
                   c_next.source_interrupt_enable[`SRC_D];

    // ****************************************
    // Pin A drives only as a toggling output
    // ****************************************
    pin_a_drives = c_next.mode_control.pin_a_function_enable &&
                   (c_next.mode_control.mode_select != `MODE_DUAL_CAPTURE);
    c_next.pin_a_oe_n = !pin_a_drives;
    c_next.hresp = 1'b0;
  end

  // ***********************************************************************
  // State registers
  // ***********************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c_reg <= '{presc_cnt: `RST_PRESCALER, prescaler: `RST_PRESCALER,
                 clock_unit: `RST_CLOCK_UNIT, mode_control: `RST_MODE_CONTROL,
                 source_interrupt_enable: `RST_FLAGS, pending: `RST_FLAGS,
                 reload_from_b: 1'b0, started_one: 1'b0, started_two: 1'b0,
                 irq_a: 1'b0, irq_b: 1'b0, pin_a_oe_n: 1'b1, hresp: 1'b0,
                 hrdata: 32'h0000_0000};
    end else begin
      c_reg <= c_next;
    end
  end

  // ***********************************************************************
  // Counters and capture/reload values keep their contents through reset
  // ***********************************************************************
  always_ff @(posedge hclk) begin
    d_reg <= d_next;
  end

  // ***********************************************************************
  // Outputs
  // ***********************************************************************
  assign hrdata = c_reg.hrdata;
  assign hresp = c_reg.hresp;
  assign timer_pin_a_out = c_reg.mode_control.pin_a_output_level;
  assign timer_pin_a_oe_n = c_reg.pin_a_oe_n;
  assign pwm_line = c_reg.mode_control.pin_a_output_level;
  assign irq_a = c_reg.irq_a;
  assign irq_b = c_reg.irq_b;
endmodule // dual_timer_io_irq_regs
`default_nettype wire

// ### core/dual_timer_defines.svh
`ifndef DUAL_TIMER_DEFINES_SVH
`define DUAL_TIMER_DEFINES_SVH

// ***********************************************************************
// Register offsets
// ***********************************************************************
`define OFS_COUNTER_ONE       6'h00
`define OFS_CAPTURE_RELOAD_A  6'h04
`define OFS_CAPTURE_RELOAD_B  6'h08
`define OFS_COUNTER_TWO       6'h0c
`define OFS_CLOCK_PRESCALER   6'h10
`define OFS_CLOCK_UNIT_CTRL   6'h14
`define OFS_MODE_CONTROL      6'h18
`define OFS_INTERRUPT_CONTROL 6'h1c
`define OFS_INTERRUPT_CLEAR   6'h20

// ***********************************************************************
// Field values and reset values
// ***********************************************************************
`define MODE_PWM              2'h0
`define MODE_DUAL_CAPTURE     2'h1
`define MODE_DUAL_INDEP       2'h2
`define MODE_CAPTURE_TIMER    2'h3
`define CSEL_PRESCALED        3'h1
`define CSEL_EXT_EVENT        3'h2
`define CSEL_PULSE_ACC        3'h3
`define SRC_A                 0
`define SRC_B                 1
`define SRC_C                 2
`define SRC_D                 3
`define COUNTER_PRESET        16'hffff
`define RST_PRESCALER         8'h00
`define RST_CLOCK_UNIT        6'h00
`define RST_MODE_CONTROL      9'h000
`define RST_FLAGS             4'h0
`endif

// ### core/dual_timer_pkg.sv
`default_nettype none
package dual_timer_pkg;

  // ***********************************************************************
  // Register layouts
  // ***********************************************************************
  typedef struct packed {
    logic       module_enable;
    logic       pin_a_output_level;
    logic       pin_b_function_enable;
    logic       pin_a_function_enable;
    logic       pulse_train_start;
    logic       pin_b_edge_select;
    logic       pin_a_edge_select;
    logic [1:0] mode_select;
  } mode_control_t;

  typedef struct packed {
    logic [2:0] two_select;
    logic [2:0] one_select;
  } clock_unit_t;

  // ***********************************************************************
  // Bus access and state
  // ***********************************************************************
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [5:0] addr;
  } bus_access_t;

  typedef struct packed {
    logic        busy;
    logic        hreadyout;
    bus_access_t access;
  } port_state_t;

  typedef struct packed {
    logic seen;
    logic prev;
  } edge_state_t;

  typedef struct packed {
    logic [7:0]    presc_cnt;
    logic [7:0]    prescaler;
    clock_unit_t   clock_unit;
    mode_control_t mode_control;
    logic [3:0]    source_interrupt_enable;
    logic [3:0]    pending;
    logic          reload_from_b;
    logic          started_one;
    logic          started_two;
    logic          irq_a;
    logic          irq_b;
    logic          pin_a_oe_n;
    logic          hresp;
    logic [31:0]   hrdata;
  } ctl_state_t;

  typedef struct packed {
    logic [15:0] counter_one;
    logic [15:0] counter_two;
    logic [15:0] capture_reload_a;
    logic [15:0] capture_reload_b;
  } data_state_t;

endpackage
`default_nettype wire

// ### core/ahb_port.sv
`default_nettype none
module ahb_port (
  // Clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // AHB-Lite address phase
  input  wire logic                        hsel,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [31:0]                 haddr,
  input  wire logic                        hready,
  // Answer and access strobe
  output logic                             hreadyout,
  output dual_timer_pkg::bus_access_t      access
);
  import dual_timer_pkg::*;

  port_state_t s_reg;
  port_state_t s_next;

  // ***********************************************************************
  // One wait state per transfer
  // ***********************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.access.valid = 1'b0;
    if (s_reg.busy) begin
      s_next.busy = 1'b0;
      s_next.hreadyout = 1'b1;
    end else if (hsel && htrans[1] && hready) begin
      s_next.busy = 1'b1;
      s_next.hreadyout = 1'b0;
      s_next.access.valid = 1'b1;
      s_next.access.write = hwrite;
      s_next.access.addr = haddr[5:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{busy: 1'b0, hreadyout: 1'b1, access: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.hreadyout;
  assign access = s_reg.access;
endmodule // ahb_port
`default_nettype wire

// ### core/pin_edge.sv
`default_nettype none
module pin_edge (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pin and edge choice
  input  wire logic pin,
  input  wire logic rising_select,
  // Valid transition
  output logic      edge_seen
);
  import dual_timer_pkg::*;

  edge_state_t s_reg;
  edge_state_t s_next;

  // ***********************************************************************
  // Edge sense, first sample after reset only primes
  // ***********************************************************************
  always_comb begin
    s_next.seen = 1'b1;
    s_next.prev = pin;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign edge_seen = s_reg.seen && (s_reg.prev != pin) && (pin == rising_select);
endmodule // pin_edge
`default_nettype wire

// ### bench/dt_monitor.sv
`default_nettype none
module dt_monitor (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Pins and lines
  input wire logic        timer_pin_a_out,
  input wire logic        timer_pin_a_oe_n,
  input wire logic        pwm_line,
  input wire logic        irq_a,
  input wire logic        irq_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************************************
  // Port checks
  // ***********************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take; hsel && htrans[1] && hready; endsequence
  sequence s_answer; !hreadyout ##1 hreadyout; endsequence
  property p_answer; s_take |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_reset; $rose(hresetn) |-> hreadyout && !irq_a && !irq_b && timer_pin_a_oe_n;
  endproperty
  a_reset: assert property (p_reset) else $error("bad value after reset");
  property p_stands; $changed(hrdata) |-> !$past(hreadyout) || !$past(hresetn); endproperty
  a_stands: assert property (p_stands) else $error("read data moved");
  property p_pwm; pwm_line == timer_pin_a_out; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm line differs from pin");
  property p_toggle;
    $changed(timer_pin_a_out) |-> !$past(timer_pin_a_oe_n) || !$past(hreadyout)
      || !$past(hresetn);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin toggled while not enabled");
  property p_fall_a; $fell(irq_a) |-> !$past(hreadyout) || !$past(hresetn); endproperty
  a_fall_a: assert property (p_fall_a) else $error("line A dropped by itself");
  property p_fall_b; $fell(irq_b) |-> !$past(hreadyout) || !$past(hresetn); endproperty
  a_fall_b: assert property (p_fall_b) else $error("line B dropped by itself");
endmodule // dt_monitor
bind dual_timer_io_irq_regs dt_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .timer_pin_a_out(timer_pin_a_out), .timer_pin_a_oe_n(timer_pin_a_oe_n),
  .pwm_line(pwm_line), .irq_a(irq_a), .irq_b(irq_b));
`default_nettype wire

// ### bench/ext_pins.sv
`default_nettype none
module ext_pins (
  // Clock
  input wire logic hclk,
  // Levels asked by the bench
  input wire logic a_lvl,
  input wire logic b_lvl,
  // Device side of pin A
  input wire logic a_out,
  input wire logic a_oe_n,
  // Levels seen by the device
  output logic     pin_a,
  output logic     pin_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic a_reg;
  logic b_reg;
  always_ff @(posedge hclk) begin
    a_reg <= a_lvl;
    b_reg <= b_lvl;
  end
  assign pin_a = a_oe_n ? a_reg : a_out;
  assign pin_b = b_reg;
endmodule // ext_pins
`default_nettype wire

// ### bench/tb_dual_timer_io_irq_regs.sv
`default_nettype none
module tb_dual_timer_io_irq_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, a_lvl, b_lvl, pa, pb;
  logic        hreadyout, hresp, pa_out, pa_oe_n, pwm_line, irq_a, irq_b;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, d, v;
  logic [5:0]  ofs [3] = '{6'h10, 6'h14, 6'h1c};
  int          n_mismatch, check_count, cycles, seed, n;
  dual_timer_io_irq_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_pin_a_in(pa),
    .timer_pin_a_out(pa_out), .timer_pin_a_oe_n(pa_oe_n), .timer_pin_b_in(pb),
    .pwm_line(pwm_line), .irq_a(irq_a), .irq_b(irq_b));
  ext_pins i_partner (.hclk(hclk), .a_lvl(a_lvl), .b_lvl(b_lvl), .a_out(pa_out),
    .a_oe_n(pa_oe_n), .pin_a(pa), .pin_b(pb));
  // ***********************************************
  // Tasks
  // ***********************************************
  function automatic logic [31:0] rb(input logic [5:0] o, input logic [31:0] x);
    return o == 6'h10 ? (x & 32'hff) : o == 6'h14 ? (x & 32'h3f) : (x & 32'hf);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] o, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {26'h0, o};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [5:0] o, input logic [31:0] x);
    bus(1'b1, o, x);
  endtask
  task automatic chk(input logic [5:0] o, input logic [31:0] e);
    bus(1'b0, o, 32'h0);
    cmp(hrdata, e);
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report;
    end
  end
  initial begin
    {hresetn, hsel, hwrite, a_lvl, b_lvl, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    seed = 87;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int o = 16; o <= 32; o += 4) chk(6'(o), 32'h0);
    wr(6'h24, $random(seed));
    chk(6'h24, 32'h0);
    for (int i = 0; i < 4; i++) foreach (ofs[k]) begin
      d = (i == 3) ? 32'h0 : $random(seed);
      wr(ofs[k], d);
      chk(ofs[k], rb(ofs[k], d));
    end
    v = $random(seed);
    wr(6'h18, 32'h129);
    wr(6'h04, v);
    wr(6'h18, 32'h029);
    wr(6'h04, ~v);
    chk(6'h04, {16'h0, v[15:0]});
    wr(6'h18, 32'h129);
    wr(6'h00, v);
    wr(6'h1c, 32'h3);
    b_lvl <= 1'b1;
    repeat (3) @(posedge hclk);
    cmp({31'h0, irq_a}, 32'h1);
    chk(6'h08, {16'h0, v[15:0]});
    chk(6'h20, 32'h2);
    a_lvl <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(6'h20, 32'h2);
    a_lvl <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(6'h04, {16'h0, v[15:0]});
    chk(6'h00, 32'hffff);
    chk(6'h20, 32'h3);
    wr(6'h20, 32'h0);
    chk(6'h20, 32'h3);
    wr(6'h20, 32'h3);
    chk(6'h20, 32'h0);
    cmp({31'h0, irq_a}, 32'h0);
    b_lvl <= 1'b0;
    wr(6'h18, 32'h10b);
    wr(6'h0c, 32'h5);
    wr(6'h14, 32'h8);
    wr(6'h1c, 32'ha);
    b_lvl <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(6'h08, 32'h5);
    for (n = 0; n < 200 && irq_b !== 1'b1; n++) @(posedge hclk);
    cmp({31'h0, irq_b}, 32'h1);
    cmp({31'h0, irq_a}, 32'h1);
    wr(6'h1c, 32'h2);
    cmp({31'h0, irq_b}, 32'h0);
    wr(6'h14, 32'h0);
    wr(6'h20, 32'hf);
    wr(6'h18, 32'h182);
    cmp({31'h0, pwm_line}, 32'h1);
    cmp({31'h0, pa_oe_n}, 32'h1);
    wr(6'h04, 32'h3);
    wr(6'h00, 32'h3);
    wr(6'h14, 32'h1);
    repeat (20) @(posedge hclk);
    cmp({31'h0, pwm_line}, 32'h1);
    wr(6'h18, 32'h1a2);
    cmp({31'h0, pa_oe_n}, 32'h0);
    for (n = 0; n < 200 && pwm_line !== 1'b0; n++) @(posedge hclk);
    cmp({31'h0, pa_out}, 32'h0);
    wr(6'h14, 32'h0);
    chk(6'h20, 32'h1);
    wr(6'h18, 32'h118);
    wr(6'h04, 32'h0);
    wr(6'h08, 32'h0);
    wr(6'h00, 32'h0);
    wr(6'h14, 32'h2);
    wr(6'h20, 32'hf);
    for (int p = 0; p < 3; p++) begin
      if (p == 1) wr(6'h18, 32'h108);
      b_lvl <= 1'b0;
      repeat (3) @(posedge hclk);
      b_lvl <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(6'h20, (p == 0) ? 32'h0 : (p == 1) ? 32'h1 : 32'h3);
    end
    wr(6'h18, 32'h101);
    wr(6'h14, 32'h1);
    wr(6'h20, 32'hf);
    chk(6'h00, 32'h0);
    a_lvl <= 1'b1;
    repeat (3) @(posedge hclk);
    a_lvl <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(6'h20, 32'h5);
    final_report;
  end
endmodule // tb_dual_timer_io_irq_regs
`default_nettype wire
